// *** status_pkg.sv ***
// constants shared by the status reporting hierarchy
package status_pkg;

   // ----------------------------------------------------------------
   // widths and register groups
   // ----------------------------------------------------------------
   localparam int          REG_W     = 16;
   localparam int          BYTE_W    = 8;
   localparam int          ADDR_W    = 5;
   localparam int          NUM_SCPI  = 3;
   localparam logic [1:0]  GRP_OPER  = 2'h0;
   localparam logic [1:0]  GRP_QUES  = 2'h1;
   localparam logic [1:0]  GRP_FREQ  = 2'h2;
   localparam logic [1:0]  GRP_IEEE  = 2'h3;

   // ----------------------------------------------------------------
   // part selectors, low three address bits
   // ----------------------------------------------------------------
   localparam logic [2:0]  PART_COND = 3'h0;
   localparam logic [2:0]  PART_RISE = 3'h1;
   localparam logic [2:0]  PART_FALL = 3'h2;
   localparam logic [2:0]  PART_EVT  = 3'h3;
   localparam logic [2:0]  PART_MASK = 3'h4;
   localparam logic [2:0]  PART_ESR  = 3'h0;
   localparam logic [2:0]  PART_ESE  = 3'h1;
   localparam logic [2:0]  PART_STB  = 3'h2;
   localparam logic [2:0]  PART_SRE  = 3'h3;

   // ----------------------------------------------------------------
   // reset values and the bit 15 keep-out mask
   // ----------------------------------------------------------------
   localparam logic [15:0] VALID_BITS = 16'h7FFF;
   localparam logic [15:0] RISE_RST   = 16'h7FFF;
   localparam logic [15:0] FALL_RST   = 16'h0000;
   localparam logic [15:0] MASK_RST   = 16'h0000;
   localparam logic [7:0]  ESE_RST    = 8'h00;
   localparam logic [7:0]  SRE_RST    = 8'h00;

   // ----------------------------------------------------------------
   // bit positions
   // ----------------------------------------------------------------
   localparam int STB_ERRQ   = 2;
   localparam int STB_QUES   = 3;
   localparam int STB_MAV    = 4;
   localparam int STB_ESB    = 5;
   localparam int STB_MSS    = 6;
   localparam int STB_OPER   = 7;
   localparam int OPER_CALIB = 0;
   localparam int QUES_FREQ  = 5;

   // response source
   typedef enum logic [1:0] {
      RSP_NONE = 2'b00,
      RSP_CMD  = 2'b01,
      RSP_POLL = 2'b10
   } rsp_src_e;

endpackage

// *** status_reg_if.sv ***
// link between the command decoder and one five-part status register
`timescale 1ns/100ps
interface status_reg_if #(
   parameter int W = 16
) ();
   logic [W-1:0] cond;
   logic [W-1:0] wdata;
   logic         rise_we;
   logic         fall_we;
   logic         mask_we;
   logic         evt_rd;
   logic [W-1:0] rise;
   logic [W-1:0] fall;
   logic [W-1:0] evts;
   logic [W-1:0] mask;
   logic         sum;

   modport owner (input cond, wdata, rise_we, fall_we, mask_we, evt_rd,
                  output rise, fall, evts, mask, sum);
   modport user  (output cond, wdata, rise_we, fall_we, mask_we, evt_rd,
                  input rise, fall, evts, mask, sum);
endinterface

// *** status_reg.sv ***
// one five-part status register: condition, edge filters, events, mask
`timescale 1ns/100ps
module status_reg #(
   parameter int W = status_pkg::REG_W
) (
   // clock and reset
   input  wire logic   clk_sys_i,
   input  wire logic   rst_b_i,
   // register link
   status_reg_if.owner sr
);
   import status_pkg::*;

   logic [W-1:0] cond_q;
   logic [W-1:0] rise_q;
   logic [W-1:0] fall_q;
   logic [W-1:0] evt_q;
   logic [W-1:0] mask_q;
   wire  [W-1:0] valid = VALID_BITS[W-1:0];
   wire  [W-1:0] cond_now = sr.cond & valid;
   wire  [W-1:0] up_edge = cond_now & ~cond_q;
   wire  [W-1:0] dn_edge = ~cond_now & cond_q;
   wire  [W-1:0] wr_val = sr.wdata & valid;

   wire  [W-1:0] latch = (up_edge & rise_q) | (dn_edge & fall_q);

   wire  [W-1:0] evt_d = (sr.evt_rd ? '0 : evt_q) | latch;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         cond_q <= '0;
         rise_q <= RISE_RST[W-1:0];
         fall_q <= FALL_RST[W-1:0];
         evt_q  <= '0;
         mask_q <= MASK_RST[W-1:0];
      end else begin
         cond_q <= cond_now;
         evt_q  <= evt_d;
         if (sr.rise_we) begin
            rise_q <= wr_val;
         end
         if (sr.fall_we) begin
            fall_q <= wr_val;
         end
         if (sr.mask_we) begin
            mask_q <= wr_val;
         end
      end
   end

   assign sr.sum  = |(evt_q & mask_q);
   assign sr.rise = rise_q;
   assign sr.fall = fall_q;
   assign sr.evts = evt_q;
   assign sr.mask = mask_q;

endmodule

// *** stb_srq.sv ***
// status byte capture, master summary and service request edge
`timescale 1ns/100ps
module stb_srq (
   // clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       rst_b_i,
   // summaries in, mask in
   input  wire logic [7:0] stb_src_i,
   input  wire logic [7:0] sre_i,
   // status byte and request out
   output logic      [7:0] stb_o,
   output logic            srq_o
);
   import status_pkg::*;

   logic [7:0] stb_q;
   logic       srq_q;

   wire  [7:0] sre_use = sre_i & ~(8'h01 << STB_MSS);
   wire  [7:0] src = stb_src_i & ~(8'h01 << STB_MSS);

   wire        mss = |(src & sre_use);
   wire  [7:0] stb_d = src | ({7'h00, mss} << STB_MSS);

   // enabled 0 to 1 raises request
   wire        srq_d = |(src & ~stb_q & sre_use);

   // byte held as a condition, refreshed every cycle
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         stb_q <= 8'h00;
         srq_q <= 1'b0;
      end else begin
         stb_q <= stb_d;
         srq_q <= srq_d;
      end
   end

   assign stb_o = stb_q;
   assign srq_o = srq_q;

endmodule

// *** status_event_hierarchy.sv ***
// top of the status reporting hierarchy with its command port
//
// Function
// - five sixteen-bit parts, same bit meaning
// - bit 15 of every part reads zero
// - condition tracks live status, read only
// - rising edge latched when rise filter set
// - falling edge latched when fall filter set
// - edge filters freely read and written
// - events latched, read only, cleared on read
// - summary is OR of enabled events
// - mask freely read and written
// - summary feeds condition of higher register
// - summaries computed continuously, propagate upward
// - status byte gathers event, operation, questionable
// - status byte is condition, bit six summary
// - status byte read by query or poll
// - request mask per bit, bit six ignored
// - enabled status bit rising raises request
// - message available bit follows output buffer
// - standard event enable masks standard events
// - operation bit 0 is calibration status
// - controller can query all status registers
// - bit 2 error queue, bit 3 questionable
// - bit 7 operation, 4 message, 5 events
`timescale 1ns/100ps
module status_event_hierarchy #(
   parameter int W = status_pkg::REG_W
) (
   // clock and reset
   input  wire logic                          clk_sys_i,
   input  wire logic                          rst_b_i,
   // register command port
   input  wire logic                          cmd_valid_i,
   input  wire logic                          cmd_write_i,
   input  wire logic [status_pkg::ADDR_W-1:0] cmd_addr_i,
   input  wire logic [W-1:0]                  cmd_wdata_i,
   input  wire logic                          poll_i,
   output logic                               rsp_valid_o,
   output logic      [W-1:0]                  rsp_data_o,
   // status sources
   input  wire logic                          calibrating_i,
   input  wire logic [W-1:0]                  oper_cond_i,
   input  wire logic [W-1:0]                  ques_cond_i,
   input  wire logic [W-1:0]                  freq_cond_i,
   input  wire logic [status_pkg::BYTE_W-1:0] std_event_i,
   input  wire logic                          errq_nonempty_i,
   input  wire logic                          msg_avail_i,
   // status byte and service request
   output logic      [status_pkg::BYTE_W-1:0] stb_o,
   output logic                               srq_o
);
   import status_pkg::*;

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------

   // group 3 holds the byte-wide registers; parts 5 to 7 of the
   // other groups decode to nothing, so writes there are dropped
   // address splits into a register group and a part
   wire [1:0] grp  = cmd_addr_i[ADDR_W-1:3];
   wire [2:0] part = cmd_addr_i[2:0];
   wire       rd_cmd = cmd_valid_i & ~cmd_write_i;
   wire       wr_cmd = cmd_valid_i & cmd_write_i;
   wire       ieee_hit = grp == GRP_IEEE;

   // standard event group strobes
   wire       esr_rd = rd_cmd & ieee_hit & (part == PART_ESR);
   wire       ese_we = wr_cmd & ieee_hit & (part == PART_ESE);
   wire       sre_we = wr_cmd & ieee_hit & (part == PART_SRE);

   // ----------------------------------------------------------------
   // scpi registers: operation, questionable, frequency
   // ----------------------------------------------------------------

   // each group gets its own link so its strobes stay private
   status_reg_if #(.W(W)) sr_if [NUM_SCPI] ();

   // per-group copies of each part, for the read mux
   logic [W-1:0] cond_a [NUM_SCPI];
   logic [W-1:0] rise_a [NUM_SCPI];
   logic [W-1:0] fall_a [NUM_SCPI];
   logic [W-1:0] evts_a [NUM_SCPI];
   logic [W-1:0] mask_a [NUM_SCPI];
   logic         sum_a  [NUM_SCPI];

   // condition inputs of each group
   logic [W-1:0] cond_src [NUM_SCPI];

   always_comb begin
      cond_src[0] = oper_cond_i;
      cond_src[0][OPER_CALIB] = calibrating_i;
   end

   always_comb begin
      cond_src[1] = ques_cond_i;
      cond_src[1][QUES_FREQ] = sum_a[2];
   end

   // lowest level has only hardware sources
   assign cond_src[2] = freq_cond_i;

   // one register per scpi group; the frequency group sits lowest
   // and reaches the questionable group through its summary bit
   genvar g;
   generate
      for (g = 0; g < NUM_SCPI; g = g + 1) begin : gen_scpi
         wire hit = grp == 2'(g);

         assign sr_if[g].cond    = cond_src[g];
         assign sr_if[g].wdata   = cmd_wdata_i;
         assign sr_if[g].rise_we = wr_cmd & hit & (part == PART_RISE);
         assign sr_if[g].fall_we = wr_cmd & hit & (part == PART_FALL);
         assign sr_if[g].mask_we = wr_cmd & hit & (part == PART_MASK);
         assign sr_if[g].evt_rd  = rd_cmd & hit & (part == PART_EVT);

         status_reg #(.W(W)) u_reg (
            .clk_sys_i (clk_sys_i),
            .rst_b_i   (rst_b_i),
            .sr        (sr_if[g])
         );

         assign cond_a[g] = cond_src[g] & VALID_BITS[W-1:0];
         assign rise_a[g] = sr_if[g].rise;
         assign fall_a[g] = sr_if[g].fall;
         assign evts_a[g] = sr_if[g].evts;
         assign mask_a[g] = sr_if[g].mask;
         assign sum_a[g]  = sr_if[g].sum;
      end
   endgenerate

   // ----------------------------------------------------------------
   // standard event register and its enable
   // ----------------------------------------------------------------

   logic [BYTE_W-1:0] esr_q;
   logic [BYTE_W-1:0] ese_q;
   logic [BYTE_W-1:0] sre_q;

   // fresh event survives the read clear
   // standard events clear on read too
   wire  [BYTE_W-1:0] esr_d = (esr_rd ? '0 : esr_q) | std_event_i;

   // event sources arrive as one-cycle pulses, so no edge filter here
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         esr_q <= '0;
      end else begin
         esr_q <= esr_d;
      end
   end

   // only the low byte of a write word is kept, upper bits dropped
   // enables and request mask reset to zero
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         ese_q <= ESE_RST;
         sre_q <= SRE_RST;
      end else begin
         if (ese_we) begin
            ese_q <= cmd_wdata_i[BYTE_W-1:0];
         end
         if (sre_we) begin
            sre_q <= cmd_wdata_i[BYTE_W-1:0];
         end
      end
   end

   // plain and-or, the summary holds no state of its own
   // enable masks the standard events
   wire esb = |(esr_q & ese_q);

   // ----------------------------------------------------------------
   // status byte and service request
   // ----------------------------------------------------------------

   logic [BYTE_W-1:0] stb_src;
   logic [BYTE_W-1:0] stb_w;
   logic              srq_w;

   always_comb begin
      stb_src = '0;
      stb_src[STB_ERRQ] = errq_nonempty_i;
      stb_src[STB_QUES] = sum_a[1];
      stb_src[STB_MAV]  = msg_avail_i;
      stb_src[STB_ESB]  = esb;
      stb_src[STB_OPER] = sum_a[0];
   end

   // the mask is applied inside, so bit 6 never triggers itself
   // byte built as a condition register
   stb_srq u_stb (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_b_i),
      .stb_src_i (stb_src),
      .sre_i     (sre_q),
      .stb_o     (stb_w),
      .srq_o     (srq_w)
   );

   // ----------------------------------------------------------------
   // read mux and response
   // ----------------------------------------------------------------

   logic [W-1:0] scpi_rd;
   logic [W-1:0] ieee_rd;
   logic [W-1:0] rsp_d;
   rsp_src_e     src;

   // reads have no side effect except on event parts, which the
   // clear strobe empties at the same edge that captures them
   // every part is readable
   always_comb begin
      scpi_rd = '0;
      if (grp != GRP_IEEE) begin
         case (part)
            PART_COND: scpi_rd = cond_a[grp];
            PART_RISE: scpi_rd = rise_a[grp];
            PART_FALL: scpi_rd = fall_a[grp];
            PART_EVT:  scpi_rd = evts_a[grp];
            PART_MASK: scpi_rd = mask_a[grp];
            default:   scpi_rd = '0;
         endcase
      end
   end

   always_comb begin
      case (part)
         PART_ESR: ieee_rd = {{(W-BYTE_W){1'b0}}, esr_q};
         PART_ESE: ieee_rd = {{(W-BYTE_W){1'b0}}, ese_q};
         PART_STB: ieee_rd = {{(W-BYTE_W){1'b0}}, stb_w};
         PART_SRE: ieee_rd = {{(W-BYTE_W){1'b0}}, sre_q};
         default:  ieee_rd = '0;
      endcase
   end

   // limitation: the controller must retry a poll that collides
   // a read command beats a poll; a poll in the same cycle is dropped
   always_comb begin
      if (rd_cmd) begin
         src = RSP_CMD;
      end else if (poll_i) begin
         src = RSP_POLL;
      end else begin
         src = RSP_NONE;
      end
   end

   // serial poll returns the status byte
   always_comb begin
      case (src)
         RSP_CMD:  rsp_d = ieee_hit ? ieee_rd : scpi_rd;
         RSP_POLL: rsp_d = {{(W-BYTE_W){1'b0}}, stb_w};
         RSP_NONE: rsp_d = '0;
         default:  rsp_d = '0;
      endcase
   end

   // the byte is registered once more so every top output leaves a
   // flop; this costs one cycle of request latency
   // registered outputs; event data is captured before its clear lands
   logic              rsp_valid_q;
   logic [W-1:0]      rsp_data_q;
   logic [BYTE_W-1:0] stb_q;
   logic              srq_q;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         rsp_valid_q <= 1'b0;
         rsp_data_q  <= '0;
         stb_q       <= '0;
         srq_q       <= 1'b0;
      end else begin
         rsp_valid_q <= src != RSP_NONE;
         rsp_data_q  <= rsp_d;
         stb_q       <= stb_w;
         srq_q       <= srq_w;
      end
   end

   assign rsp_valid_o = rsp_valid_q;
   assign rsp_data_o  = rsp_data_q;
   assign stb_o       = stb_q;
   assign srq_o       = srq_q;

endmodule

// *** seh_props.sv ***
// port-level properties of the status reporting hierarchy
`timescale 1ns/100ps
module seh_props #(
   parameter int W = 16
) (
   // clock and reset
   input wire logic         clk_sys_i,
   input wire logic         rst_b_i,
   // command port
   input wire logic         cmd_valid_i,
   input wire logic         cmd_write_i,
   input wire logic         poll_i,
   input wire logic         rsp_valid_o,
   input wire logic [W-1:0] rsp_data_o,
   // status
   input wire logic         errq_nonempty_i,
   input wire logic         msg_avail_i,
   input wire logic [7:0]   stb_o,
   input wire logic         srq_o
);
   // ----------------------------------------
   // clocking
   // ----------------------------------------
   // reset aborts any attempt in flight
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);

   // levels held long enough to cross the byte pipeline
   sequence s_mav_on;
      msg_avail_i [*4];
   endsequence
   sequence s_errq_on;
      errq_nonempty_i [*4];
   endsequence

   chk_read_answer: assert property (cmd_valid_i && !cmd_write_i |=> rsp_valid_o)
      else $error("read got no answer");
   chk_write_quiet: assert property (cmd_valid_i && cmd_write_i && !poll_i |=> !rsp_valid_o)
      else $error("write gave an answer");
   chk_top_bit_zero: assert property (rsp_valid_o |-> !rsp_data_o[15])
      else $error("bit 15 read as one");
   chk_poll_answer: assert property (poll_i && !cmd_valid_i |=> rsp_valid_o && rsp_data_o[15:8] == 8'h00
                                     && rsp_data_o[7:0] == stb_o)
      else $error("poll answer missing or wide");
   chk_srq_cause: assert property (srq_o |-> (stb_o & ~$past(stb_o) & 8'hBF) != 8'h00)
      else $error("request without a rising byte bit");
   chk_mss_sum: assert property (stb_o[6] |-> (stb_o & 8'hBF) != 8'h00)
      else $error("summary bit set alone");
   chk_unused_low: assert property (stb_o[1:0] == 2'h0)
      else $error("unused byte bits set");
   chk_mav_follow: assert property (s_mav_on |-> stb_o[4])
      else $error("message bit not following");
   chk_errq_follow: assert property (s_errq_on |-> stb_o[2])
      else $error("error queue bit not following");
   chk_rsp_idle: assert property (!rsp_valid_o |-> rsp_data_o == '0)
      else $error("data left on idle response port");
endmodule

bind status_event_hierarchy seh_props #(.W(W)) u_props (
   .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid_i),
   .cmd_write_i(cmd_write_i), .poll_i(poll_i), .rsp_valid_o(rsp_valid_o),
   .rsp_data_o(rsp_data_o), .errq_nonempty_i(errq_nonempty_i),
   .msg_avail_i(msg_avail_i), .stb_o(stb_o), .srq_o(srq_o)
);

// *** remote_ctl.sv ***
// remote controller model issuing register commands and polls
`timescale 1ns/100ps
module remote_ctl (
   // clock
   input  wire logic        clk_sys_i,
   // command side
   output logic             cmd_valid_o,
   output logic             cmd_write_o,
   output logic [4:0]       cmd_addr_o,
   output logic [15:0]      cmd_wdata_o,
   output logic             poll_o,
   // answers
   input  wire logic        rsp_valid_i,
   input  wire logic [15:0] rsp_data_i
);
   // idle at time zero
   initial begin
      cmd_valid_o = 1'b0;
      cmd_write_o = 1'b0;
      cmd_addr_o  = 5'h00;
      cmd_wdata_o = 16'h0000;
      poll_o      = 1'b0;
   end

   task automatic xfer(input logic pl, input logic w, input logic [4:0] a,
                       input logic [15:0] d, output logic [15:0] q);
      @(posedge clk_sys_i);
      poll_o      <= pl;
      cmd_valid_o <= !pl;
      cmd_write_o <= w;
      cmd_addr_o  <= a;
      cmd_wdata_o <= d;
      @(posedge clk_sys_i);
      // released lines flip so stale data is never mistaken
      poll_o      <= 1'b0;
      cmd_valid_o <= 1'b0;
      cmd_write_o <= ~w;
      cmd_addr_o  <= ~a;
      cmd_wdata_o <= ~d;
      // answer stands only for the cycle after the taking edge
      #1;
      q = (rsp_valid_i === 1'b1) ? rsp_data_i : 16'hXXXX;
   endtask
endmodule

// *** tb_top.sv ***
// self-checking bench for the status reporting hierarchy
`timescale 1ns/100ps
module tb_top;
   logic        clk_sys_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic        calibrating_i = 1'b0;
   logic        errq_nonempty_i = 1'b0;
   logic        msg_avail_i = 1'b0;
   logic [15:0] oper_cond_i = 16'h0000;
   logic [15:0] ques_cond_i = 16'h0000;
   logic [15:0] freq_cond_i = 16'h0000;
   logic [7:0]  std_event_i = 8'h00;
   logic        cmd_valid_i, cmd_write_i, poll_i, rsp_valid_o, srq_o;
   logic [4:0]  cmd_addr_i;
   logic [15:0] cmd_wdata_i, rsp_data_o, q;
   logic [7:0]  stb_o;
   int          mismatches = 0, n_tests = 0, n_srq = 0, ev, pc, c, r, f;
   int          pa [3] = '{1, 2, 4};
   logic [31:0] seed = 32'hA988;
   // setup for the byte path: filters, masks, enables
   logic [4:0]  sa [11] = '{5'h01, 5'h02, 5'h04, 5'h09, 5'h0A, 5'h0C, 5'h11, 5'h12, 5'h14, 5'h19, 5'h1B};
   logic [15:0] sd [11] = '{16'h7FFF, 16'h0000, 16'h0008, 16'h7FFF, 16'h0000, 16'h0020,
                            16'h7FFF, 16'h0000, 16'h0002, 16'h0001, 16'h0080};

   always #20 clk_sys_i = ~clk_sys_i;

   status_event_hierarchy dut (
      .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i),
      .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i), .poll_i(poll_i), .rsp_valid_o(rsp_valid_o),
      .rsp_data_o(rsp_data_o), .calibrating_i(calibrating_i), .oper_cond_i(oper_cond_i),
      .ques_cond_i(ques_cond_i), .freq_cond_i(freq_cond_i), .std_event_i(std_event_i),
      .errq_nonempty_i(errq_nonempty_i), .msg_avail_i(msg_avail_i), .stb_o(stb_o), .srq_o(srq_o));

   remote_ctl ctl (
      .clk_sys_i(clk_sys_i), .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i), .cmd_addr_o(cmd_addr_i),
      .cmd_wdata_o(cmd_wdata_i), .poll_o(poll_i), .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o));

   // count request pulses, one per cycle high
   always @(posedge clk_sys_i) begin
      if (srq_o === 1'b1) begin
         n_srq++;
      end
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      n_tests++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      ctl.xfer(1'b0, 1'b1, a, d, q);
   endtask

   task automatic rd(input logic [4:0] a, input logic [15:0] e, input string nm);
      ctl.xfer(1'b0, 1'b0, a, 16'h0000, q);
      chk(nm, e, q);
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask

   task wrap_up();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // hang guard, far beyond the few hundred cycles needed
   initial begin
      #400000;
      mismatches++;
      wrap_up();
   end

   initial begin
      repeat (12) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      wait_n(1);
      // reset values, then random write and double readback
      for (int g = 0; g < 3; g++) begin
         rd(5'(g * 8 + 1), 16'h7FFF, "rise");
         rd(5'(g * 8 + 2), 16'h0000, "fall");
         rd(5'(g * 8 + 3), 16'h0000, "events");
         rd(5'(g * 8 + 4), 16'h0000, "mask");
         foreach (pa[i]) begin
            r = xs();
            wr(5'(g * 8 + pa[i]), r[15:0]);
            rd(5'(g * 8 + pa[i]), r[15:0] & 16'h7FFF, "rw part");
            rd(5'(g * 8 + pa[i]), r[15:0] & 16'h7FFF, "rw again");
         end
      end
      rd(5'h19, 16'h0000, "ese");
      rd(5'h1B, 16'h0000, "sre");
      rd(5'h07, 16'h0000, "unmapped");
      // random conditions through random edge filters
      r = xs() & 32'h7FFF;
      f = xs() & 32'h7FFF;
      wr(5'h01, r[15:0]);
      wr(5'h02, f[15:0]);
      wr(5'h00, 16'hFFFF);
      pc = 0;
      ev = 0;
      repeat (8) begin
         c = xs() & 32'h7FFF;
         @(posedge clk_sys_i);
         oper_cond_i   <= {1'b1, c[14:1], ~c[0]};
         calibrating_i <= c[0];
         ev = ev | (~pc & c & r) | (pc & ~c & f);
         pc = c;
         wait_n(2);
         rd(5'h00, pc[15:0], "condition");
      end
      rd(5'h03, ev[15:0], "edges");
      rd(5'h03, 16'h0000, "cleared");
      // path from low registers to status byte and request
      @(posedge clk_sys_i);
      oper_cond_i   <= 16'h0000;
      calibrating_i <= 1'b0;
      foreach (sa[i]) begin
         wr(sa[i], sd[i]);
      end
      ctl.xfer(1'b0, 1'b0, 5'h03, 16'h0000, q);
      n_srq = 0;
      @(posedge clk_sys_i);
      oper_cond_i     <= 16'h0008;
      freq_cond_i     <= 16'h0002;
      errq_nonempty_i <= 1'b1;
      msg_avail_i     <= 1'b1;
      std_event_i     <= 8'h01;
      @(posedge clk_sys_i);
      std_event_i     <= 8'h00;
      wait_n(10);
      chk("stb", 16'h00FC, {8'h00, stb_o});
      chk("srq count", 16'h0001, 16'(n_srq));
      ctl.xfer(1'b1, 1'b0, 5'h00, 16'h0000, q);
      chk("poll", 16'h00FC, q);
      rd(5'h1A, 16'h00FC, "stb query");
      rd(5'h18, 16'h0001, "esr");
      rd(5'h03, 16'h0008, "oper events");
      wr(5'h1B, 16'h00FF);
      wait_n(6);
      chk("stb low", 16'h005C, {8'h00, stb_o});
      chk("srq bit6", 16'h0001, 16'(n_srq));
      // edge landing on the clearing read
      @(posedge clk_sys_i);
      oper_cond_i <= 16'h0000;
      wait_n(3);
      fork
         rd(5'h03, 16'h0000, "same cycle");
         begin
            @(posedge clk_sys_i);
            oper_cond_i <= 16'h0008;
         end
      join
      wait_n(4);
      rd(5'h03, 16'h0008, "kept event");
      chk("srq again", 16'h0002, 16'(n_srq));
      wrap_up();
   end
endmodule
